//--- shared/adcsq_pkg.sv
// Purpose: constants and types for the converter sequencing control block
// Assumes: APB slave, 32-bit data, byte address = 4 * printed index
// Notes: one aligned word per register, data in low 8 bits
package adcsq_pkg;
  localparam logic [7:0] ADCSQ_IDX_CTRL_A = 8'h0E;
  localparam logic [7:0] ADCSQ_IDX_CTRL_B = 8'h0F;
  localparam logic [7:0] ADCSQ_IDX_STATUS = 8'h26;
  localparam logic [7:0] ADCSQ_IDX_UPPER = 8'h27;
  localparam logic [7:0] ADCSQ_CTRL_A_RESET = 8'h10;
  localparam logic [7:0] ADCSQ_CTRL_B_RESET = 8'h10;
  localparam logic [7:0] ADCSQ_CTRL_B_MASK = 8'h3E;
  localparam logic [7:0] ADCSQ_UNSTABLE = 8'h0A;
  localparam int ADCSQ_START_BIT = 7;
  localparam int ADCSQ_GATE_BIT = 4;
  localparam int ADCSQ_LADDER_BIT = 5;
  localparam logic [1:0] ADCSQ_MODE_OFF = 2'h0;
  localparam logic [1:0] ADCSQ_MODE_SINGLE = 2'h1;
  localparam logic [1:0] ADCSQ_MODE_REPEAT = 2'h3;
  localparam int ADCSQ_CNT_W = 12;
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'h0,
    ADCSQ_CONV = 2'h1
  } adcsq_state_t;
  // conversion length in clock periods, zero for reserved codes
  function automatic logic [11:0] adcsq_conv_len(input logic div, input logic [2:0] code);
    logic [11:0] len;
    len = 12'h000;
    if (!div) begin
      unique case (code)
        3'h0: len = 12'h027;
        3'h2: len = 12'h04E;
        3'h3: len = 12'h09C;
        3'h4: len = 12'h138;
        3'h5: len = 12'h270;
        3'h6: len = 12'h4E0;
        default: len = 12'h000;
      endcase
    end else begin
      unique case (code)
        3'h0: len = 12'h027;
        3'h2: len = 12'h09C;
        3'h3: len = 12'h138;
        3'h4: len = 12'h270;
        3'h5: len = 12'h4E0;
        3'h6: len = 12'h830;
        default: len = 12'h000;
      endcase
    end
    return len;
  endfunction
endpackage

//--- verilog/adcsq_timer.sv
`timescale 1ns/1ps
// Purpose: conversion length counter
// Assumes: len nonzero when load pulses
// Notes: fin pulses for one cycle after len cycles
module adcsq_timer #(
  parameter int CNT_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic abort,
  input wire logic [CNT_W-1:0] len,
  output logic fin
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
    logic fin;
  } adcsq_tmr_t;
  adcsq_tmr_t r, next_r;

  // longest conversion needs the full package width
  if (CNT_W < adcsq_pkg::ADCSQ_CNT_W) begin : g_width_check
    $error("timer counter too narrow for longest conversion");
  end

  always_comb begin
    next_r = r;
    next_r.fin = 1'b0;
    if (abort) begin
      next_r.run = 1'b0;
    end else if (load) begin
      next_r.run = 1'b1;
      next_r.cnt = len - CNT_W'(1);
    end else if (r.run) begin
      if (r.cnt == '0) begin
        next_r.run = 1'b0;
        next_r.fin = 1'b1;
      end else begin
        next_r.cnt = r.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign fin = r.fin;
endmodule

//--- verilog/adcsq_ctrl.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// Purpose: sequencing control of a 10-bit converter, APB registers
// Assumes: analog comparator returns result with conv_done timing from this block
// Notes: one clock period counted per high-frequency clock period
module adcsq_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_power,
  input wire logic [9:0] analog_result,
  output logic [3:0] channel_select,
  output logic analog_input_gate,
  output logic ladder_connect,
  output logic sample_enable,
  output logic conversion_done_irq
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef struct packed {
    adcsq_pkg::adcsq_state_t st;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [9:0] result;
    logic done_flag;
    logic busy_flag;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic ladder;
    logic sample;
  } adcsq_regs_t;
  adcsq_regs_t r, next_r;

  logic load;
  logic abort;
  logic fin;
  logic [11:0] len;
  logic setup;
  logic wr;
  logic rd;
  logic [9:0] idx;
  logic [1:0] mode;
  logic map_hit;

  // register index match, used by decode and checks
  function automatic logic adcsq_at(input logic [9:0] a, input logic [7:0] ridx);
    return a == {2'h0, ridx};
  endfunction

  assign mode = r.ctrl_a[6:5];
  assign len = adcsq_pkg::adcsq_conv_len(1'b0, r.ctrl_b[3:1]);
  assign setup = psel && !penable;
  assign idx = paddr[11:2];
  assign wr = setup && pwrite;
  assign rd = setup && !pwrite;
  assign map_hit = (paddr[1:0] == 2'h0) && (adcsq_at(idx, adcsq_pkg::ADCSQ_IDX_CTRL_A)
    || adcsq_at(idx, adcsq_pkg::ADCSQ_IDX_CTRL_B) || adcsq_at(idx, adcsq_pkg::ADCSQ_IDX_STATUS)
    || adcsq_at(idx, adcsq_pkg::ADCSQ_IDX_UPPER));

  // divider select is tied low; divider-1 table kept in function
  adcsq_timer #(
    .CNT_W(adcsq_pkg::ADCSQ_CNT_W)
  ) i_adcsq_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(load),
    .abort(abort),
    .len(len),
    .fin(fin)
  );

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    next_r = r;
    load = 1'b0;
    abort = 1'b0;
    next_r.irq = 1'b0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    // APB: answer one cycle after setup
    if (setup) begin
      next_r.pready = 1'b1;
      next_r.pslverr = !map_hit;
      next_r.prdata = '0;
    end
    if (rd && map_hit) begin
      if (idx == {2'h0, adcsq_pkg::ADCSQ_IDX_CTRL_A}) begin
        next_r.prdata = {24'h000000, r.ctrl_a};
      end else if (idx == {2'h0, adcsq_pkg::ADCSQ_IDX_CTRL_B}) begin
        next_r.prdata = {24'h000000, r.ctrl_b};
      end else if (idx == {2'h0, adcsq_pkg::ADCSQ_IDX_STATUS}) begin
        next_r.prdata = {24'h000000, r.result[1:0], r.done_flag, r.busy_flag,
          adcsq_pkg::ADCSQ_UNSTABLE[3:0]};
      end else begin
        next_r.prdata = {24'h000000, r.result[9:2]};
        next_r.done_flag = 1'b0;
      end
    end
    if (wr && map_hit && !low_power) begin
      if (idx == {2'h0, adcsq_pkg::ADCSQ_IDX_CTRL_A}) begin
        next_r.ctrl_a = pwdata[7:0];
      end else if (idx == {2'h0, adcsq_pkg::ADCSQ_IDX_CTRL_B}) begin
        next_r.ctrl_b = pwdata[7:0] & adcsq_pkg::ADCSQ_CTRL_B_MASK;
      end
    end
    // sequencing
    unique case (r.st)
      adcsq_pkg::ADCSQ_IDLE: begin
        if (r.ctrl_a[adcsq_pkg::ADCSQ_START_BIT] && mode != adcsq_pkg::ADCSQ_MODE_OFF
            && len != '0) begin
          load = 1'b1;
          next_r.st = adcsq_pkg::ADCSQ_CONV;
          next_r.busy_flag = 1'b1;
          next_r.done_flag = 1'b0;
          next_r.ctrl_a[adcsq_pkg::ADCSQ_START_BIT] = 1'b0;
        end
      end
      adcsq_pkg::ADCSQ_CONV: begin
        if (mode == adcsq_pkg::ADCSQ_MODE_OFF) begin
          abort = 1'b1;
          next_r.st = adcsq_pkg::ADCSQ_IDLE;
          next_r.busy_flag = 1'b0;
        end else if (fin) begin
          next_r.result = analog_result;
          next_r.done_flag = 1'b1;
          next_r.irq = 1'b1;
          if (mode == adcsq_pkg::ADCSQ_MODE_REPEAT) begin
            load = 1'b1;
            next_r.busy_flag = 1'b1;
          end else begin
            next_r.st = adcsq_pkg::ADCSQ_IDLE;
            next_r.busy_flag = 1'b0;
          end
        end
      end
      default: begin
        next_r.st = adcsq_pkg::ADCSQ_IDLE;
      end
    endcase
    if (low_power) begin
      abort = 1'b1;
      next_r.st = adcsq_pkg::ADCSQ_IDLE;
      next_r.busy_flag = 1'b0;
      next_r.ctrl_a = adcsq_pkg::ADCSQ_CTRL_A_RESET;
      next_r.ctrl_b = adcsq_pkg::ADCSQ_CTRL_B_RESET;
      next_r.result = '0;
      next_r.done_flag = 1'b0;
      next_r.irq = 1'b0;
    end
    next_r.ladder = next_r.ctrl_b[adcsq_pkg::ADCSQ_LADDER_BIT]
      || next_r.st == adcsq_pkg::ADCSQ_CONV;
    next_r.sample = next_r.st == adcsq_pkg::ADCSQ_CONV;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: adcsq_pkg::ADCSQ_IDLE, ctrl_a: adcsq_pkg::ADCSQ_CTRL_A_RESET,
        ctrl_b: adcsq_pkg::ADCSQ_CTRL_B_RESET, result: 10'h000, done_flag: 1'b0,
        busy_flag: 1'b0, prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0,
        irq: 1'b0, ladder: 1'b0, sample: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign channel_select = r.ctrl_a[3:0];
  assign analog_input_gate = r.ctrl_a[adcsq_pkg::ADCSQ_GATE_BIT];
  assign ladder_connect = r.ladder;
  assign sample_enable = r.sample;
  assign conversion_done_irq = r.irq;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  start_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    load && r.st == adcsq_pkg::ADCSQ_IDLE |=> !r.ctrl_a[adcsq_pkg::ADCSQ_START_BIT] || $past(wr))
    else $error("start bit not cleared");
  start_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    load && !low_power |=> r.busy_flag)
    else $error("busy not set on start");
  done_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.done_flag) |-> r.irq)
    else $error("done without interrupt");
  upper_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && map_hit && adcsq_at(idx, adcsq_pkg::ADCSQ_IDX_UPPER) && !fin |=> !r.done_flag)
    else $error("upper read kept done");
  low_power_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_power |=> r.ctrl_a == adcsq_pkg::ADCSQ_CTRL_A_RESET && !r.busy_flag)
    else $error("low power did not reset");
  abort_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    abort |=> $stable(r.result) || $past(low_power))
    else $error("aborted result stored");
  ladder_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.sample |-> r.ladder)
    else $error("ladder off during conversion");
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("no apb answer");
  repeat_a: assert property (@(posedge pclk) disable iff (!presetn)
    fin && mode == adcsq_pkg::ADCSQ_MODE_REPEAT && !low_power |=> r.busy_flag)
    else $error("repeat did not restart");
  single_c: cover property (@(posedge pclk) disable iff (!presetn)
    mode == adcsq_pkg::ADCSQ_MODE_SINGLE && fin);
  repeat_c: cover property (@(posedge pclk) disable iff (!presetn)
    mode == adcsq_pkg::ADCSQ_MODE_REPEAT && fin);
  abort_c: cover property (@(posedge pclk) disable iff (!presetn) abort && r.busy_flag);
  busy_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.busy_flag == r.sample)
    else $error("busy and sampling disagree");
  irq_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.irq |=> !r.irq)
    else $error("interrupt longer than one cycle");
  off_no_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == adcsq_pkg::ADCSQ_IDLE && mode == adcsq_pkg::ADCSQ_MODE_OFF |=> r.st == adcsq_pkg::ADCSQ_IDLE)
    else $error("start while converter off");
  reserved_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == adcsq_pkg::ADCSQ_IDLE && len == '0 |=> r.st == adcsq_pkg::ADCSQ_IDLE)
    else $error("start on reserved time code");
  restart_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    load && r.st == adcsq_pkg::ADCSQ_IDLE && !low_power |=> $stable(r.result) && !r.done_flag)
    else $error("restart lost old result");
  status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && map_hit && adcsq_at(idx, adcsq_pkg::ADCSQ_IDX_STATUS)
    |=> r.prdata[5] == $past(r.done_flag) && r.prdata[4] == $past(r.busy_flag))
    else $error("status flags misplaced");
  lp_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_power && wr |=> r.ctrl_b == adcsq_pkg::ADCSQ_CTRL_B_RESET && analog_input_gate)
    else $error("write accepted in low power");
  ladder_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !r.sample && !r.ctrl_b[adcsq_pkg::ADCSQ_LADDER_BIT] |-> !r.ladder)
    else $error("ladder on while idle");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !map_hit |=> pslverr)
    else $error("unmapped access not flagged");
  lowpower_c: cover property (@(posedge pclk) disable iff (!presetn) low_power && r.busy_flag);
  upper_read_c: cover property (@(posedge pclk) disable iff (!presetn)
    rd && adcsq_at(idx, adcsq_pkg::ADCSQ_IDX_UPPER) && r.done_flag);
endmodule

//--- bench/adcsq_analog_model.sv
`timescale 1ns/1ps
// Purpose: analog comparator and sample-hold stand-in
// Assumes: result is taken while sample_enable is high
// Notes: value depends on channel; drifts when not sampling
module adcsq_analog_model (
  input wire logic pclk,
  input wire logic [3:0] channel_select,
  input wire logic sample_enable,
  output logic [9:0] analog_result
);
  // ----------------------------------------
  // comparator output
  // ----------------------------------------
  logic [9:0] held = 10'h000;
  always @(posedge pclk) begin
    if (sample_enable) begin
      held <= {channel_select, 6'h2D};
    end else begin
      // not sampling: no stable value to rely on
      held <= ~held;
    end
  end
  assign analog_result = held;
endmodule

//--- bench/tb_adc_sequencing_control.sv
`timescale 1ns/1ps
// Purpose: register-level bench for the converter control
// Assumes: APB slave answers within 20 cycles
// Notes: conversion lengths measured on sample_enable and irq
module tb_adc_sequencing_control;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam logic [7:0] ia = adcsq_pkg::ADCSQ_IDX_CTRL_A;
  localparam logic [7:0] ib = adcsq_pkg::ADCSQ_IDX_CTRL_B;
  localparam logic [7:0] ist = adcsq_pkg::ADCSQ_IDX_STATUS;
  localparam logic [7:0] iu = adcsq_pkg::ADCSQ_IDX_UPPER;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic low_power = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, e, analog_input_gate, ladder_connect, sample_enable, conversion_done_irq;
  logic se_q = 1'b0;
  logic [9:0] analog_result;
  logic [3:0] channel_select;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0 = 0;
  int len = 0;
  int irq_n = 0;
  always #12.5 pclk = ~pclk;
  adcsq_ctrl i_adcsq_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_power(low_power),
    .analog_result(analog_result), .channel_select(channel_select), .analog_input_gate(analog_input_gate),
    .ladder_connect(ladder_connect), .sample_enable(sample_enable), .conversion_done_irq(conversion_done_irq));
  adcsq_analog_model i_adcsq_analog_model (.pclk(pclk), .channel_select(channel_select),
    .sample_enable(sample_enable), .analog_result(analog_result));
  // settled values, away from the launching edge
  // one process: edge test reads se_q before it is updated
  always @(negedge pclk) begin
    cyc++;
    if (sample_enable === 1'b1 && se_q !== 1'b1) begin
      t0 = cyc;
    end
    se_q = sample_enable;
    if (conversion_done_irq === 1'b1) begin
      irq_n++;
      len = cyc - t0;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken at the rising edge that samples pready high
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        close_out();
      end
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] m, input logic [7:0] x);
    apb(1'b0, i, 8'h00);
    check(q & {24'h0, m}, {24'h0, x});
  endtask
  task automatic wait_irq(input int k);
    int n;
    for (n = 0; n < 4000 && irq_n < k; n++) begin
      @(posedge pclk);
    end
    if (irq_n < k) begin
      fail_count++;
      close_out();
    end
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [3:0] ch;
    logic [2:0] code;
    int k;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ia, 8'hFF, 8'h10);
    rd(ib, 8'h3F, 8'h10);
    check({31'h0, analog_input_gate}, 32'h1);
    apb(1'b0, 8'h30, 8'h00);
    check({31'h0, e}, 32'h1);
    $display("test reset and map ended");
    for (k = 0; k < 3; k++) begin
      code = (k == 0) ? 3'h0 : 3'(k + 1);
      ch = 4'(k * 15 / 2);
      apb(1'b1, ib, {3'h0, 1'b1, code, 1'b0});
      apb(1'b1, ia, {4'h2, ch});
      check({28'h0, channel_select}, {28'h0, ch});
      check({30'h0, analog_input_gate, ladder_connect}, 32'h0);
      apb(1'b1, ia, {4'hA, ch});
      check({30'h0, sample_enable, ladder_connect}, 32'h3);
      rd(ia, 8'hFF, {4'h2, ch});
      rd(ist, 8'h30, 8'h10);
      wait_irq(k + 1);
      check({31'h0, len >= (39 << k) && len <= (39 << k) + 2}, 32'h1);
      rd(ist, 8'hF0, 8'h60);
      rd(iu, 8'hFF, {ch, 4'hB});
      rd(ist, 8'h30, 8'h00);
    end
    $display("test single conversions ended");
    apb(1'b1, ib, 8'h30);
    check({31'h0, ladder_connect}, 32'h1);
    apb(1'b1, ia, 8'hE5);
    wait_irq(5);
    rd(iu, 8'hFF, 8'h5B);
    rd(ist, 8'h30, 8'h10);
    apb(1'b1, ia, 8'h05);
    rd(ist, 8'h30, 8'h00);
    repeat (200) @(posedge pclk);
    check(irq_n, 5);
    apb(1'b1, ia, 8'h85);
    repeat (100) @(posedge pclk);
    check(irq_n, 5);
    apb(1'b1, ib, 8'h12);
    apb(1'b1, ia, 8'hA5);
    repeat (50) @(posedge pclk);
    rd(ist, 8'h10, 8'h00);
    check(irq_n, 5);
    $display("test repeat and abort ended");
    apb(1'b1, ib, 8'h30);
    rd(ist, 8'h10, 8'h10);
    low_power <= 1'b1;
    @(posedge pclk);
    rd(ist, 8'h10, 8'h00);
    apb(1'b1, ia, 8'h2A);
    rd(ia, 8'hFF, 8'h10);
    rd(ib, 8'h3F, 8'h10);
    check({31'h0, analog_input_gate}, 32'h1);
    low_power <= 1'b0;
    @(posedge pclk);
    $display("test low power ended");
    close_out();
  end
endmodule
